// File: logic/ppa_defs.svh
// constants for the parallel port block with analog pin handling
`ifndef PPA_DEFS_SVH
`define PPA_DEFS_SVH

`define PPA_ADDR_W 16
`define PPA_DATA_W 16
`define PPA_NPORT 5

`define PPA_DIR_B 16'h02c6
`define PPA_PIN_B 16'h02c8
`define PPA_LAT_B 16'h02ca
`define PPA_DIR_C 16'h02cc
`define PPA_PIN_C 16'h02ce
`define PPA_LAT_C 16'h02d0
`define PPA_DIR_D 16'h02d2
`define PPA_PIN_D 16'h02d4
`define PPA_LAT_D 16'h02d6
`define PPA_DIR_E 16'h02d8
`define PPA_PIN_E 16'h02da
`define PPA_LAT_E 16'h02dc
`define PPA_DIR_F 16'h02de
`define PPA_PIN_F 16'h02e0
`define PPA_LAT_F 16'h02e2
`define PPA_ASEL 16'h02e4

// implemented pin masks per port
`define PPA_MASK_B 16'h01ff
`define PPA_MASK_C 16'he000
`define PPA_MASK_D 16'h000f
`define PPA_MASK_E 16'h013f
`define PPA_MASK_F 16'h007f
// analog pins live on port b
`define PPA_MASK_ASEL 16'h01ff

`define PPA_LAT_RST 16'h0000
`define PPA_ASEL_RST 16'h0000
`define PPA_ZERO 16'h0000

`endif

// File: logic/ppa_pkg.sv
// types for the parallel port block
package ppa_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ppa_req_t;

    typedef struct packed {
        logic [15:0] dir;
        logic [15:0] lat;
    } ppa_port_t;
endpackage

// File: logic/ppa_gpio.sv
// parallel i/o ports b..f with analog pin select and register port
`include "ppa_defs.svh"

module ppa_gpio (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic [79:0] PIN_IN,
    output logic [79:0] PIN_OUT,
    output logic [79:0] PIN_OE,
    output logic [15:0] ANALOG_EN,
    output logic [15:0] ANALOG_FROM_PORT
);
    ppa_pkg::ppa_req_t req;
    // one register per port and kind, so each has its own process
    logic [15:0] dir_b_ff;
    logic [15:0] dir_c_ff;
    logic [15:0] dir_d_ff;
    logic [15:0] dir_e_ff;
    logic [15:0] dir_f_ff;
    logic [15:0] lat_b_ff;
    logic [15:0] lat_c_ff;
    logic [15:0] lat_d_ff;
    logic [15:0] lat_e_ff;
    logic [15:0] lat_f_ff;
    ppa_pkg::ppa_port_t prt_view [0:4];
    logic [15:0] pin_view [0:4];
    logic [4:0] wr_dir;
    logic [4:0] wr_lat;
    logic [15:0] asel_ff;
    logic [79:0] sync1_ff;
    logic [79:0] sync2_ff;
    logic [15:0] rdata_ff;
    // registered pad drive, one pair per port
    logic [15:0] out_b_ff;
    logic [15:0] out_c_ff;
    logic [15:0] out_d_ff;
    logic [15:0] out_e_ff;
    logic [15:0] out_f_ff;
    logic [15:0] oe_b_ff;
    logic [15:0] oe_c_ff;
    logic [15:0] oe_d_ff;
    logic [15:0] oe_e_ff;
    logic [15:0] oe_f_ff;
    logic [15:0] an_en_ff;
    logic [15:0] an_port_ff;
    logic [15:0] nxt_rdata;

    assign req.addr = ADDR;
    assign req.wdata = WDATA;
    assign req.wr = WR;
    assign req.rd = RD;

    function automatic logic [15:0] port_mask(input int p);
        unique case (p)
            0: port_mask = `PPA_MASK_B;
            1: port_mask = `PPA_MASK_C;
            2: port_mask = `PPA_MASK_D;
            3: port_mask = `PPA_MASK_E;
            default: port_mask = `PPA_MASK_F;
        endcase
    endfunction

    // register kind: 0 direction, 1 pin level, 2 latch; port index or -1
    function automatic int dec_port(input logic [15:0] a);
        unique case (a)
            `PPA_DIR_B, `PPA_PIN_B, `PPA_LAT_B: dec_port = 0;
            `PPA_DIR_C, `PPA_PIN_C, `PPA_LAT_C: dec_port = 1;
            `PPA_DIR_D, `PPA_PIN_D, `PPA_LAT_D: dec_port = 2;
            `PPA_DIR_E, `PPA_PIN_E, `PPA_LAT_E: dec_port = 3;
            `PPA_DIR_F, `PPA_PIN_F, `PPA_LAT_F: dec_port = 4;
            default: dec_port = -1;
        endcase
    endfunction

    function automatic int dec_kind(input logic [15:0] a);
        unique case (a)
            `PPA_DIR_B, `PPA_DIR_C, `PPA_DIR_D, `PPA_DIR_E, `PPA_DIR_F: dec_kind = 0;
            `PPA_PIN_B, `PPA_PIN_C, `PPA_PIN_D, `PPA_PIN_E, `PPA_PIN_F: dec_kind = 1;
            default: dec_kind = 2;
        endcase
    endfunction

    // pins pass two flops before any logic reads them
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= PIN_IN;
            sync2_ff <= sync1_ff;
        end
    end

    // write enables, one bit per port; unmapped addresses enable nothing
    always_comb begin
        wr_dir = 5'h00;
        wr_lat = 5'h00;
        for (int p = 0; p < `PPA_NPORT; p++) begin
            if (req.wr && dec_port(req.addr) == p) begin
                if (dec_kind(req.addr) == 0) begin
                    wr_dir[p] = 1'b1;
                end else begin
                    wr_lat[p] = 1'b1; // pin-level writes land in the latch
                end
            end
        end
    end

    // port b direction; reset leaves every pin an input
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_b_ff <= `PPA_MASK_B;
        end else if (wr_dir[0]) begin
            dir_b_ff <= req.wdata & `PPA_MASK_B;
        end
    end

    // port c direction
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_c_ff <= `PPA_MASK_C;
        end else if (wr_dir[1]) begin
            dir_c_ff <= req.wdata & `PPA_MASK_C;
        end
    end

    // port d direction
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_d_ff <= `PPA_MASK_D;
        end else if (wr_dir[2]) begin
            dir_d_ff <= req.wdata & `PPA_MASK_D;
        end
    end

    // port e direction
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_e_ff <= `PPA_MASK_E;
        end else if (wr_dir[3]) begin
            dir_e_ff <= req.wdata & `PPA_MASK_E;
        end
    end

    // port f direction
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_f_ff <= `PPA_MASK_F;
        end else if (wr_dir[4]) begin
            dir_f_ff <= req.wdata & `PPA_MASK_F;
        end
    end

    // port b latch; unimplemented bits never store a 1
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lat_b_ff <= `PPA_LAT_RST;
        end else if (wr_lat[0]) begin
            lat_b_ff <= req.wdata & `PPA_MASK_B;
        end
    end

    // port c latch
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lat_c_ff <= `PPA_LAT_RST;
        end else if (wr_lat[1]) begin
            lat_c_ff <= req.wdata & `PPA_MASK_C;
        end
    end

    // port d latch
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lat_d_ff <= `PPA_LAT_RST;
        end else if (wr_lat[2]) begin
            lat_d_ff <= req.wdata & `PPA_MASK_D;
        end
    end

    // port e latch
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lat_e_ff <= `PPA_LAT_RST;
        end else if (wr_lat[3]) begin
            lat_e_ff <= req.wdata & `PPA_MASK_E;
        end
    end

    // port f latch
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lat_f_ff <= `PPA_LAT_RST;
        end else if (wr_lat[4]) begin
            lat_f_ff <= req.wdata & `PPA_MASK_F;
        end
    end

    // gathered view for the loops below
    assign prt_view[0] = '{dir: dir_b_ff, lat: lat_b_ff};
    assign prt_view[1] = '{dir: dir_c_ff, lat: lat_c_ff};
    assign prt_view[2] = '{dir: dir_d_ff, lat: lat_d_ff};
    assign prt_view[3] = '{dir: dir_e_ff, lat: lat_e_ff};
    assign prt_view[4] = '{dir: dir_f_ff, lat: lat_f_ff};

    // synchronised pin levels; unimplemented pins read 0
    always_comb begin
        for (int p = 0; p < `PPA_NPORT; p++) begin
            pin_view[p] = sync2_ff[p*`PPA_DATA_W +: `PPA_DATA_W] & port_mask(p);
        end
        // analog input buffer is off, so the pin has no digital meaning
        pin_view[0] = pin_view[0] & ~asel_ff;
    end

    // analog pin select register
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            asel_ff <= `PPA_ASEL_RST;
        end else if (req.wr && req.addr == `PPA_ASEL) begin
            asel_ff <= req.wdata & `PPA_MASK_ASEL;
        end
    end

    // read mux; pin reads see synchronised pins, so a read right after a write shows stale data
    always_comb begin
        int p;
        int k;
        p = dec_port(req.addr);
        k = dec_kind(req.addr);
        nxt_rdata = `PPA_ZERO;
        if (req.rd) begin
            if (req.addr == `PPA_ASEL) begin
                nxt_rdata = asel_ff;
            end else begin
                for (int i = 0; i < `PPA_NPORT; i++) begin
                    if (p == i) begin
                        unique case (k)
                            0: nxt_rdata = prt_view[i].dir;
                            1: nxt_rdata = pin_view[i];
                            default: nxt_rdata = prt_view[i].lat;
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_ff <= `PPA_ZERO;
        end else begin
            rdata_ff <= nxt_rdata; // read data lag one cycle
        end
    end

    // port b pad drive; enable is high where an implemented pin's direction bit is 0
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_b_ff <= `PPA_ZERO;
            oe_b_ff <= `PPA_ZERO;
        end else begin
            out_b_ff <= lat_b_ff;
            oe_b_ff <= ~dir_b_ff & `PPA_MASK_B;
        end
    end

    // port c pad drive
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_c_ff <= `PPA_ZERO;
            oe_c_ff <= `PPA_ZERO;
        end else begin
            out_c_ff <= lat_c_ff;
            oe_c_ff <= ~dir_c_ff & `PPA_MASK_C;
        end
    end

    // port d pad drive
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_d_ff <= `PPA_ZERO;
            oe_d_ff <= `PPA_ZERO;
        end else begin
            out_d_ff <= lat_d_ff;
            oe_d_ff <= ~dir_d_ff & `PPA_MASK_D;
        end
    end

    // port e pad drive
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_e_ff <= `PPA_ZERO;
            oe_e_ff <= `PPA_ZERO;
        end else begin
            out_e_ff <= lat_e_ff;
            oe_e_ff <= ~dir_e_ff & `PPA_MASK_E;
        end
    end

    // port f pad drive
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_f_ff <= `PPA_ZERO;
            oe_f_ff <= `PPA_ZERO;
        end else begin
            out_f_ff <= lat_f_ff;
            oe_f_ff <= ~dir_f_ff & `PPA_MASK_F;
        end
    end

    // converter hookup; digital-configured pins never reach it
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            an_en_ff <= `PPA_ZERO;
        end else begin
            an_en_ff <= asel_ff;
        end
    end

    // an analog pin left as output converts the level the port drives
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            an_port_ff <= `PPA_ZERO;
        end else begin
            an_port_ff <= asel_ff & ~dir_b_ff;
        end
    end

    assign RDATA = rdata_ff;
    assign PIN_OUT = {out_f_ff, out_e_ff, out_d_ff, out_c_ff, out_b_ff};
    assign PIN_OE = {oe_f_ff, oe_e_ff, oe_d_ff, oe_c_ff, oe_b_ff};
    assign ANALOG_EN = an_en_ff;
    assign ANALOG_FROM_PORT = an_port_ff;
endmodule // ppa_gpio

// File: test/ppa_gpio_assertions.sv
// checker for the parallel port block
`include "ppa_defs.svh"
module ppa_gpio_chk (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic [79:0] PIN_IN,
    input wire logic [79:0] PIN_OUT,
    input wire logic [79:0] PIN_OE,
    input wire logic [15:0] ANALOG_EN,
    input wire logic [15:0] ANALOG_FROM_PORT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    wire logic [79:0] impl = {`PPA_MASK_F, `PPA_MASK_E, `PPA_MASK_D, `PPA_MASK_C, `PPA_MASK_B};
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data outside slot");
    a_unimpl_zero: assert property (((PIN_OE | PIN_OUT) & ~impl) == 80'h0)
        else $error("unimplemented pin active");
    a_dir_to_oe: assert property (WR && ADDR == `PPA_DIR_B ##1 !(WR && ADDR == `PPA_DIR_B)
        |=> PIN_OE[15:0] == (~$past(WDATA, 2) & `PPA_MASK_B)) else $error("enable not from direction");
    a_pin_wr_latch: assert property (WR && ADDR == `PPA_PIN_B ##1 !(WR && ADDR inside {`PPA_PIN_B, `PPA_LAT_B})
        |=> PIN_OUT[15:0] == ($past(WDATA, 2) & `PPA_MASK_B)) else $error("pin write missed latch");
    a_from_port: assert property ((ANALOG_FROM_PORT & ~(ANALOG_EN & PIN_OE[15:0])) == 16'h0)
        else $error("converter source wrong");
    a_analog_read: assert property ($past(RD) && $past(ADDR) == `PPA_PIN_B && $stable(ANALOG_EN)
        |-> (RDATA & ANALOG_EN) == 16'h0) else $error("analog pin read nonzero");
    a_analog_span: assert property ((ANALOG_EN & ~`PPA_MASK_ASEL) == 16'h0)
        else $error("converter sees non-analog pin");
    a_unmapped_rd: assert property ($past(RD) && $past(ADDR) == 16'h0100 |-> RDATA == 16'h0)
        else $error("unmapped read nonzero");
    cover property (ANALOG_FROM_PORT != 16'h0);
    cover property (WR && ADDR == `PPA_ASEL);
    cover property ($past(RD) && RDATA != 16'h0);
endmodule // ppa_gpio_chk
bind ppa_gpio ppa_gpio_chk chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ANALOG_EN(ANALOG_EN),
    .ANALOG_FROM_PORT(ANALOG_FROM_PORT));

// File: test/ppa_gpio_bench.sv
// self-checking bench for the parallel port block
`include "ppa_defs.svh"
module ppa_gpio_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 0, SYS_RST = 1, WR = 0, RD = 0;
    logic [15:0] ADDR = 16'h0, WDATA = 16'h0, RDATA, ANALOG_EN, ANALOG_FROM_PORT, b;
    logic [79:0] PIN_IN = '1, PIN_OUT, PIN_OE;
    logic [15:0] msk [5] = '{`PPA_MASK_B, `PPA_MASK_C, `PPA_MASK_D, `PPA_MASK_E, `PPA_MASK_F};
    int n_mismatch = 0, tests_run = 0;
    ppa_gpio uut (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ANALOG_EN(ANALOG_EN),
        .ANALOG_FROM_PORT(ANALOG_FROM_PORT));
    initial forever #5 MCLK = ~MCLK;
    task chk(input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [15:0] a, d);
        @(posedge MCLK);
        {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    // data only stands in the cycle after the strobe
    task rd(input logic [15:0] a, exp);
        @(posedge MCLK);
        {RD, ADDR} <= {1'b1, a};
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge MCLK);
        SYS_RST <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            b = 16'h02c6 + 16'(6 * i);
            rd(b, msk[i]);
            rd(b + 16'h0004, 16'h0000);
            rd(b + 16'h0002, msk[i]);
            wr(b + 16'h0004, 16'hffff);
            rd(b + 16'h0004, msk[i]);
            wr(b + 16'h0002, 16'h5a5a);
            rd(b + 16'h0004, 16'h5a5a & msk[i]);
            wr(b, 16'h0000);
            rd(b, 16'h0000);
            chk(PIN_OE[16 * i +: 16], msk[i]);
            chk(PIN_OUT[16 * i +: 16], 16'h5a5a & msk[i]);
        end
        $display("test registers done");
        wr(`PPA_DIR_B, 16'h01ff);
        wr(`PPA_ASEL, 16'h0005);
        rd(`PPA_PIN_B, 16'h01fa);
        chk(ANALOG_EN, 16'h0005);
        chk(ANALOG_FROM_PORT, 16'h0000);
        wr(`PPA_DIR_B, 16'h01fe);
        rd(`PPA_PIN_B, 16'h01fa);
        chk(ANALOG_FROM_PORT, 16'h0001);
        PIN_IN <= {5{16'h3c96}};
        repeat (3) @(posedge MCLK);
        rd(`PPA_PIN_B, 16'h0092);
        rd(`PPA_PIN_D, 16'h0006);
        wr(16'h0100, 16'hffff);
        rd(16'h0100, 16'h0000);
        $display("test analog and unmapped done");
        close_out;
    end
    // run needs about 115 cycles at most
    initial begin
        #30000;
        n_mismatch++;
        close_out;
    end
endmodule // ppa_gpio_bench
